/* src/t2cr_timer.sv */
/*
 * 16-bit up timer/counter with reload/capture register, sticky flags,
 * interrupt and serial baud ticks, behind an Avalon-MM slave.
 * Assumes pins synchronous to i_clk and an Avalon master that holds
 * each request until it sees waitrequest low.
 */
`timescale 1ns/10ps
// Overview of operation
// - count source 0: counter increments every second system clock cycle
// - count source 1: counter increments on each falling edge of count pin
// - reload mode: counter loads from reload/capture register on overflow
// - reload mode with trigger enabled, no serial clock selected: trigger pin falling edge reloads counter
// - capture mode with trigger enabled, no serial clock selected: trigger falling edge captures counter
// - serial clock selection ignores capture select and forces reload on overflow
// - reload/capture value held as low and high bytes, reset zero
// - running counter readable and writable as low and high bytes, reset zero
// - overflow flag set on overflow unless serving as baud clock
// - trigger flag set on trigger-caused capture or reload
// - selected serial clock gets counter overflow in serial modes one and three
module t2cr_timer
   import t2cr_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire logic [7:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [31:0] i_writedata,
   input wire logic [3:0] i_byteenable,
   output logic [31:0] o_readdata,
   output logic o_waitrequest,
   input wire logic i_ext_count_pin,
   input wire logic i_ext_trigger_pin,
   input wire logic [1:0] i_uart_mode,
   output logic o_rx_baud_tick,
   output logic o_tx_baud_tick,
   output logic o_irq
);

   // ****************************************************************
   // state
   // ****************************************************************
   t2cr_ctrl_s ctrl_reg;
   t2cr_ctrl_s ctrl_next;
   t2cr_flags_s flags_reg;
   t2cr_flags_s flags_next;
   t2cr_flags_s mask_reg;
   t2cr_flags_s mask_next;
   logic [15:0] cnt_reg;
   logic [15:0] cnt_next;
   logic [15:0] rc_reg;
   logic [15:0] rc_next;
   logic [0:0] presc_reg;
   logic [0:0] presc_next;
   logic count_pin_reg;
   logic trig_pin_reg;
   logic rd_valid_reg;
   logic [31:0] rdata_reg;
   logic rx_tick_reg;
   logic tx_tick_reg;

   // ****************************************************************
   // bus decode
   // ****************************************************************
   // only byte lane 0 carries data; other lanes are ignored on write
   wire wr_lane0 = i_ce & i_write & i_byteenable[0];
   wire wr_status = wr_lane0 & (i_address == T2CR_IDX_STATUS);
   wire wr_mask = wr_lane0 & (i_address == T2CR_IDX_MASK);
   wire wr_ctrl = wr_lane0 & (i_address == T2CR_IDX_CTRL);
   wire wr_rc_low = wr_lane0 & (i_address == T2CR_IDX_RC_LOW);
   wire wr_rc_high = wr_lane0 & (i_address == T2CR_IDX_RC_HIGH);
   wire wr_cnt_low = wr_lane0 & (i_address == T2CR_IDX_CNT_LOW);
   wire wr_cnt_high = wr_lane0 & (i_address == T2CR_IDX_CNT_HIGH);
   wire cnt_wr = wr_cnt_low | wr_cnt_high;
   wire rc_wr = wr_rc_low | wr_rc_high;
   wire [7:0] wbyte = i_writedata[7:0];

   // read mux; unmapped indices read as zero
   wire [7:0] rd_byte =
      (i_address == T2CR_IDX_STATUS) ? {6'h00, flags_reg} :
      (i_address == T2CR_IDX_MASK) ? {6'h00, mask_reg} :
      (i_address == T2CR_IDX_CTRL) ? {2'h0, ctrl_reg} :
      (i_address == T2CR_IDX_RC_LOW) ? rc_reg[7:0] :
      (i_address == T2CR_IDX_RC_HIGH) ? rc_reg[15:8] :
      (i_address == T2CR_IDX_CNT_LOW) ? cnt_reg[7:0] :
      (i_address == T2CR_IDX_CNT_HIGH) ? cnt_reg[15:8] : 8'h00;

   // reads take one wait cycle so read data comes from a flop
   assign o_waitrequest = ~i_ce | (i_read & ~rd_valid_reg);
   assign o_readdata = rdata_reg;

   // ****************************************************************
   // count events
   // ****************************************************************
   // pins are synchronous, so one delay flop is enough for edge detection
   wire count_fall = count_pin_reg & ~i_ext_count_pin;
   wire trig_fall = trig_pin_reg & ~i_ext_trigger_pin;
   wire presc_hit = (presc_reg == T2CR_PRESC_LAST);
   // timer mode: one increment per two clocks; counter mode: pin edge
   wire tick = ctrl_reg.run & (ctrl_reg.cnt_src ? count_fall : presc_hit);
   wire ovf_evt = tick & (cnt_reg == T2CR_COUNT_MAX);
   wire baud_mode = ctrl_reg.rx_sel | ctrl_reg.tx_sel;
   wire reload_on_ovf = ~ctrl_reg.cap_sel | baud_mode;
   // the trigger pin only acts while no serial clock selection is made
   wire trig_evt = trig_fall & ctrl_reg.trig_en & ~baud_mode;
   wire trig_reload = trig_evt & ~ctrl_reg.cap_sel;
   wire trig_capture = trig_evt & ctrl_reg.cap_sel;
   wire uart_mode13 = (i_uart_mode == T2CR_UART_MODE1) | (i_uart_mode == T2CR_UART_MODE3);
   wire [15:0] cnt_inc = 16'(cnt_reg + 16'h0001);

   // ****************************************************************
   // next-state logic
   // ****************************************************************
   // prescaler free-runs only while timing and keeps its phase when stopped, so the first tick is one or two clocks out
   always_comb begin
      presc_next = presc_reg;
      if (ctrl_reg.run & ~ctrl_reg.cnt_src) begin
         presc_next = presc_hit ? 1'b0 : 1'(presc_reg + 1'b1);
      end
   end

   // counter: software write beats count and reload in the same cycle
   always_comb begin
      cnt_next = cnt_reg;
      if (tick) begin
         cnt_next = (ovf_evt & reload_on_ovf) ? rc_reg : cnt_inc;
      end
      if (trig_reload) begin
         cnt_next = rc_reg;
      end
      if (wr_cnt_low) begin
         cnt_next[7:0] = wbyte;
      end
      if (wr_cnt_high) begin
         cnt_next[15:8] = wbyte;
      end
   end

   // reload/capture register: capture takes both bytes in one cycle
   always_comb begin
      rc_next = rc_reg;
      if (trig_capture) begin
         rc_next = cnt_reg;
      end
      if (wr_rc_low) begin
         rc_next[7:0] = wbyte;
      end
      if (wr_rc_high) begin
         rc_next[15:8] = wbyte;
      end
   end

   // sticky flags: a hardware set wins over a write-one clear
   always_comb begin
      flags_next = flags_reg;
      if (wr_status) begin
         flags_next = flags_reg & ~t2cr_flags_s'(wbyte[1:0]);
      end
      if (ovf_evt & ~baud_mode) begin
         flags_next.ovf = 1'b1;
      end
      if (trig_evt) begin
         flags_next.trig = 1'b1;
      end
   end

   assign ctrl_next = wr_ctrl ? t2cr_ctrl_s'(wbyte[5:0]) : ctrl_reg;
   assign mask_next = wr_mask ? t2cr_flags_s'(wbyte[1:0]) : mask_reg;

   // ****************************************************************
   // registers
   // ****************************************************************
   // timer state, frozen while the clock enable is low
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_reg <= T2CR_RST_COUNT;
         rc_reg <= T2CR_RST_COUNT;
         presc_reg <= 1'b0;
         count_pin_reg <= 1'b0;
         trig_pin_reg <= 1'b0;
      end else if (i_ce) begin
         cnt_reg <= cnt_next;
         rc_reg <= rc_next;
         presc_reg <= presc_next;
         count_pin_reg <= i_ext_count_pin;
         trig_pin_reg <= i_ext_trigger_pin;
      end
   end

   // control, flags and mask
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl_reg <= T2CR_RST_CTRL;
         flags_reg <= T2CR_RST_FLAGS;
         mask_reg <= T2CR_RST_FLAGS;
      end else if (i_ce) begin
         ctrl_reg <= ctrl_next;
         flags_reg <= flags_next;
         mask_reg <= mask_next;
      end
   end

   // read path and baud ticks
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rd_valid_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         rx_tick_reg <= 1'b0;
         tx_tick_reg <= 1'b0;
      end else if (i_ce) begin
         rd_valid_reg <= i_read & ~rd_valid_reg;
         rdata_reg <= (i_read & ~rd_valid_reg) ? {24'h000000, rd_byte} : rdata_reg;
         rx_tick_reg <= ovf_evt & ctrl_reg.rx_sel & uart_mode13;
         tx_tick_reg <= ovf_evt & ctrl_reg.tx_sel & uart_mode13;
      end
   end

   assign o_rx_baud_tick = rx_tick_reg;
   assign o_tx_baud_tick = tx_tick_reg;
   // level interrupt from registered flags and mask
   assign o_irq = |(flags_reg & mask_reg);

   // ****************************************************************
   // assertions
   // ****************************************************************
   property p_timer_step;
      @(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && ctrl_reg.run && !ctrl_reg.cnt_src && !cnt_wr && !trig_reload
         && presc_reg == 1'b0 && !wr_ctrl)
      ##1 (i_ce && !cnt_wr && !trig_reload && !ovf_evt && !wr_ctrl)
      |=> cnt_reg == 16'($past(cnt_reg, 2) + 16'h0001);
   endproperty
   a_timer_step: assert property (p_timer_step) else $error("timer step missed");

   property p_counter_edge;
      @(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && ctrl_reg.run && ctrl_reg.cnt_src && !cnt_wr && !trig_reload && !ovf_evt)
      |=> cnt_reg == ($past(count_fall) ? 16'($past(cnt_reg) + 16'h0001) : $past(cnt_reg));
   endproperty
   a_counter_edge: assert property (p_counter_edge) else $error("edge count wrong");

   property p_ovf_reload;
      @(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && ovf_evt && (!ctrl_reg.cap_sel || baud_mode) && !cnt_wr)
      |=> cnt_reg == $past(rc_reg);
   endproperty
   a_ovf_reload: assert property (p_ovf_reload) else $error("no overflow reload");

   property p_trig_reload;
      @(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && trig_fall && ctrl_reg.trig_en && !ctrl_reg.cap_sel && !baud_mode && !cnt_wr)
      |=> cnt_reg == $past(rc_reg);
   endproperty
   a_trig_reload: assert property (p_trig_reload) else $error("no trigger reload");

   property p_capture;
      @(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && trig_fall && ctrl_reg.trig_en && ctrl_reg.cap_sel && !baud_mode && !rc_wr)
      |=> rc_reg == $past(cnt_reg) && flags_reg.trig;
   endproperty
   a_capture: assert property (p_capture) else $error("capture missed counter value");

   property p_ovf_flag;
      @(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && ovf_evt && !baud_mode) |=> flags_reg.ovf;
   endproperty
   a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not set");

   property p_tx_tick;
      @(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && ovf_evt && ctrl_reg.tx_sel && uart_mode13) |=> o_tx_baud_tick ##1 !o_tx_baud_tick;
   endproperty
   a_tx_tick: assert property (p_tx_tick) else $error("transmit baud tick missing");

   property p_read_answer;
      @(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && i_read && o_waitrequest) ##1 (i_ce && i_read) |-> !o_waitrequest;
   endproperty
   a_read_answer: assert property (p_read_answer) else $error("read wait too long");

   property p_rx_tick;
      @(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && ovf_evt && ctrl_reg.rx_sel && uart_mode13) |=> o_rx_baud_tick;
   endproperty
   a_rx_tick: assert property (p_rx_tick) else $error("receive baud tick missing");

   property p_trig_flag;
      @(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && trig_fall && ctrl_reg.trig_en && !baud_mode) |=> flags_reg.trig;
   endproperty
   a_trig_flag: assert property (p_trig_flag) else $error("trigger flag not set");

   // a baud clock overflow must leave a clear overflow flag clear
   property p_baud_flag;
      @(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && ovf_evt && baud_mode && !flags_reg.ovf && !wr_status) |=> !flags_reg.ovf;
   endproperty
   a_baud_flag: assert property (p_baud_flag) else $error("flag set in baud mode");

   property p_cap_keep;
      @(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && trig_fall && ctrl_reg.trig_en && ctrl_reg.cap_sel && !baud_mode && !cnt_wr
         && !tick) |=> cnt_reg == $past(cnt_reg);
   endproperty
   a_cap_keep: assert property (p_cap_keep) else $error("capture moved counter");

endmodule // t2cr_timer

/* src/t2cr_pkg.sv */
/*
 * Shared constants and types for the 16-bit timer/counter with reload and capture.
 * Assumes a 32-bit Avalon-MM slave whose address port carries the word index.
 */
package t2cr_pkg;

   // ****************************************************************
   // register word indices (byte address is four times the index)
   // ****************************************************************
   localparam logic [7:0] T2CR_IDX_STATUS = 8'hC6;
   localparam logic [7:0] T2CR_IDX_MASK = 8'hC7;
   localparam logic [7:0] T2CR_IDX_CTRL = 8'hC8;
   localparam logic [7:0] T2CR_IDX_RC_LOW = 8'hCA;
   localparam logic [7:0] T2CR_IDX_RC_HIGH = 8'hCB;
   localparam logic [7:0] T2CR_IDX_CNT_LOW = 8'hCC;
   localparam logic [7:0] T2CR_IDX_CNT_HIGH = 8'hCD;

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int T2CR_CTRL_CAP_SEL_BIT = 0;
   localparam int T2CR_CTRL_CNT_SRC_BIT = 1;
   localparam int T2CR_CTRL_RUN_BIT = 2;
   localparam int T2CR_CTRL_TRIG_EN_BIT = 3;
   localparam int T2CR_CTRL_TX_SEL_BIT = 4;
   localparam int T2CR_CTRL_RX_SEL_BIT = 5;
   localparam int T2CR_FLAG_OVF_BIT = 0;
   localparam int T2CR_FLAG_TRIG_BIT = 1;

   // ****************************************************************
   // reset values and timing
   // ****************************************************************
   localparam logic [7:0] T2CR_RST_BYTE = 8'h00;
   localparam logic [15:0] T2CR_RST_COUNT = 16'h0000;
   localparam logic [15:0] T2CR_COUNT_MAX = 16'hFFFF;
   localparam logic [1:0] T2CR_RST_FLAGS = 2'h0;
   localparam logic [5:0] T2CR_RST_CTRL = 6'h00;
   localparam int T2CR_PRESC_DIV = 2;
   localparam logic [0:0] T2CR_PRESC_LAST = 1'(T2CR_PRESC_DIV - 1);
   localparam logic [1:0] T2CR_UART_MODE1 = 2'h1;
   localparam logic [1:0] T2CR_UART_MODE3 = 2'h3;

   // ****************************************************************
   // carriers
   // ****************************************************************
   typedef struct packed {
      logic rx_sel;
      logic tx_sel;
      logic trig_en;
      logic run;
      logic cnt_src;
      logic cap_sel;
   } t2cr_ctrl_s;

   typedef struct packed {
      logic trig;
      logic ovf;
   } t2cr_flags_s;

endpackage

/* verif/t2cr_pins.sv */
/*
 * Far-side model: external count and trigger pins and the serial port.
 * Assumes the bench calls its tasks just after a rising edge of i_clk.
 */
`timescale 1ns/10ps
// ****************************************************************
// pins and serial port
// ****************************************************************
module t2cr_pins (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_rx_tick,
   input wire logic i_tx_tick,
   output logic o_count_pin,
   output logic o_trigger_pin,
   output logic [1:0] o_uart_mode
);
   int rx_ticks = 0;
   int tx_ticks = 0;

   // pins idle high so that a release never reads as a falling edge
   initial begin
      o_count_pin = 1'b1;
      o_trigger_pin = 1'b1;
      o_uart_mode = 2'h0;
   end

   // serial port counts the baud pulses it receives
   always @(posedge i_clk) begin
      if (i_rst_n === 1'b1 && i_rx_tick === 1'b1) rx_ticks++;
      if (i_rst_n === 1'b1 && i_tx_tick === 1'b1) tx_ticks++;
   end

   // low for two cycles so the edge detector sees each level
   task automatic count_edges(input int n);
      repeat (n) begin
         @(posedge i_clk);
         o_count_pin <= 1'b0;
         repeat (2) @(posedge i_clk);
         o_count_pin <= 1'b1;
         @(posedge i_clk);
      end
   endtask

   task automatic trigger();
      @(posedge i_clk);
      o_trigger_pin <= 1'b0;
      repeat (2) @(posedge i_clk);
      o_trigger_pin <= 1'b1;
      @(posedge i_clk);
   endtask

   task automatic set_mode(input logic [1:0] m);
      @(posedge i_clk);
      o_uart_mode <= m;
   endtask
endmodule // t2cr_pins

/* verif/testbench.sv */
/*
 * Self-checking bench for the timer/counter with reload and capture.
 * Assumes an Avalon slave that holds waitrequest high until it can answer.
 */
`timescale 1ns/10ps
module testbench;
   import t2cr_pkg::*;
   logic i_clk, i_rst_n, i_read, i_write, o_waitrequest, o_rx_baud_tick, o_tx_baud_tick, o_irq;
   logic [7:0] i_address;
   logic [15:0] q;
   logic ce;
   logic [31:0] i_writedata, o_readdata;
   logic [3:0] i_byteenable;
   logic cnt_pin, trg_pin;
   logic [1:0] umode;
   logic [15:0] v;
   logic [7:0] idx [8] = '{8'hC6, 8'hC7, 8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hC9};
   int num_errors = 0;
   int check_count = 0;
   int rx0, tx0;

   t2cr_timer u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(ce), .i_address(i_address),
      .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
      .i_byteenable(i_byteenable), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
      .i_ext_count_pin(cnt_pin), .i_ext_trigger_pin(trg_pin), .i_uart_mode(umode),
      .o_rx_baud_tick(o_rx_baud_tick), .o_tx_baud_tick(o_tx_baud_tick), .o_irq(o_irq));
   t2cr_pins u_pins (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_rx_tick(o_rx_baud_tick),
      .i_tx_tick(o_tx_baud_tick), .o_count_pin(cnt_pin), .o_trigger_pin(trg_pin),
      .o_uart_mode(umode));

   // ****************************************************************
   // clock, checks and bus access
   // ****************************************************************
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end

   task automatic results();
      if (num_errors == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   // waitrequest and read data sampled at the rising edge, before the flops move
   // readdata bits 15:8 come back too, so compares also see them stay zero
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
         input logic [3:0] be, output logic [15:0] r);
      @(posedge i_clk);
      i_address <= a;
      i_writedata <= {24'h000000, d};
      i_byteenable <= be;
      i_write <= w;
      i_read <= !w;
      do @(posedge i_clk); while (o_waitrequest !== 1'b0);
      r = o_readdata[15:0];
      i_write <= 1'b0;
      i_read <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [15:0] r;
      acc(1'b1, a, d, 4'h1, r);
   endtask

   task automatic rd(input logic [7:0] a, output logic [15:0] r);
      acc(1'b0, a, 8'h00, 4'h1, r);
   endtask

   // counter held still by the callers, so byte order needs no carry care
   task automatic rd16(input logic [7:0] a, output logic [15:0] r);
      logic [15:0] hi;
      logic [15:0] lo;
      rd(a + 8'h01, hi);
      rd(a, lo);
      r = {hi[7:0], lo[7:0]};
   endtask

   // watchdog well beyond the several hundred cycles the tests take
   initial begin
      repeat (30000) @(posedge i_clk);
      num_errors++;
      results();
   end

   // ****************************************************************
   // tests
   // ****************************************************************
   initial begin
      i_rst_n = 1'b0;
      i_read = 1'b0;
      i_write = 1'b0;
      i_address = 8'h00;
      i_writedata = 32'h00000000;
      i_byteenable = 4'h0;
      ce = 1'b1;
      repeat (6) @(posedge i_clk);
      i_rst_n <= 1'b1;
      // reset values, unmapped index included
      foreach (idx[i]) begin
         rd(idx[i], q);
         check(q, 16'h0000);
      end
      // byte registers read back; disabled byte lane and unmapped write ignored
      for (int i = 3; i < 7; i++) wr(idx[i], idx[i] ^ 8'h96);
      acc(1'b1, T2CR_IDX_RC_LOW, 8'h11, 4'h0, q);
      wr(8'hC9, 8'h77);
      for (int i = 3; i < 8; i++) begin
         rd(idx[i], q);
         check(q, (i == 7) ? 16'h0000 : 16'(idx[i] ^ 8'h96));
      end
      // timer mode: one step every second cycle
      wr(T2CR_IDX_CNT_LOW, 8'h00);
      wr(T2CR_IDX_CNT_HIGH, 8'h00);
      wr(T2CR_IDX_CTRL, 8'h04);
      repeat (40) @(posedge i_clk);
      wr(T2CR_IDX_CTRL, 8'h00);
      rd16(T2CR_IDX_CNT_LOW, v);
      check(16'(v >= 19 && v <= 22), 16'h0001);
      // overflow reloads the high byte, sets flag and interrupt
      wr(T2CR_IDX_RC_LOW, 8'h34);
      wr(T2CR_IDX_RC_HIGH, 8'h12);
      wr(T2CR_IDX_CNT_LOW, 8'hFE);
      wr(T2CR_IDX_CNT_HIGH, 8'hFF);
      wr(T2CR_IDX_MASK, 8'h01);
      wr(T2CR_IDX_CTRL, 8'h04);
      for (int k = 0; k < 100 && o_irq !== 1'b1; k++) @(posedge i_clk);
      wr(T2CR_IDX_CTRL, 8'h00);
      rd(T2CR_IDX_CNT_HIGH, q);
      check(q, 16'h0012);
      rd(T2CR_IDX_STATUS, q);
      check(q, 16'h0001);
      check(16'(o_irq), 16'h0001);
      wr(T2CR_IDX_STATUS, 8'h01);
      @(negedge i_clk);
      check(16'(o_irq), 16'h0000);
      // counter mode: five falling edges on the count pin
      wr(T2CR_IDX_CNT_LOW, 8'h00);
      wr(T2CR_IDX_CNT_HIGH, 8'h00);
      wr(T2CR_IDX_CTRL, 8'h06);
      u_pins.count_edges(5);
      wr(T2CR_IDX_CTRL, 8'h00);
      rd16(T2CR_IDX_CNT_LOW, v);
      check(v, 16'h0005);
      // clock enable low freezes counting and holds waitrequest high
      wr(T2CR_IDX_CNT_LOW, 8'h00);
      wr(T2CR_IDX_CTRL, 8'h06);
      @(posedge i_clk);
      ce <= 1'b0;
      @(negedge i_clk);
      check(16'(o_waitrequest), 16'h0001);
      u_pins.count_edges(3);
      @(posedge i_clk);
      ce <= 1'b1;
      wr(T2CR_IDX_CTRL, 8'h00);
      rd16(T2CR_IDX_CNT_LOW, v);
      check(v, 16'h0000);
      // trigger in reload mode, counter stopped
      wr(T2CR_IDX_MASK, 8'h02);
      wr(T2CR_IDX_RC_LOW, 8'hCD);
      wr(T2CR_IDX_RC_HIGH, 8'hAB);
      wr(T2CR_IDX_CTRL, 8'h08);
      u_pins.trigger();
      rd16(T2CR_IDX_CNT_LOW, v);
      check(v, 16'hABCD);
      rd(T2CR_IDX_STATUS, q);
      check(q, 16'h0002);
      check(16'(o_irq), 16'h0001);
      wr(T2CR_IDX_STATUS, 8'h02);
      // trigger in capture mode leaves the counter alone
      wr(T2CR_IDX_CNT_LOW, 8'h78);
      wr(T2CR_IDX_CNT_HIGH, 8'h56);
      wr(T2CR_IDX_CTRL, 8'h09);
      u_pins.trigger();
      rd16(T2CR_IDX_RC_LOW, v);
      check(v, 16'h5678);
      rd16(T2CR_IDX_CNT_LOW, v);
      check(v, 16'h5678);
      wr(T2CR_IDX_STATUS, 8'h03);
      // baud clock checked in all four serial modes, ticking in modes one and three only; capture select and trigger overridden
      wr(T2CR_IDX_RC_LOW, 8'h00);
      wr(T2CR_IDX_RC_HIGH, 8'hFF);
      for (int m = 0; m < 4; m++) begin
         u_pins.set_mode(2'(m));
         rx0 = u_pins.rx_ticks;
         tx0 = u_pins.tx_ticks;
         wr(T2CR_IDX_CNT_LOW, 8'hF0);
         wr(T2CR_IDX_CNT_HIGH, 8'hFF);
         wr(T2CR_IDX_CTRL, 8'h3D);
         u_pins.trigger();
         repeat (56) @(posedge i_clk);
         wr(T2CR_IDX_CTRL, 8'h00);
         check(16'(u_pins.rx_ticks - rx0), 16'(m % 2));
         check(16'(u_pins.tx_ticks - tx0), 16'(m % 2));
         rd(T2CR_IDX_CNT_HIGH, q);
         check(q, 16'h00FF);
         rd(T2CR_IDX_RC_LOW, q);
         check(q, 16'h0000);
         rd(T2CR_IDX_STATUS, q);
         check(q, 16'h0000);
      end
      results();
   end
endmodule // testbench
